// ==== urdr_map.svh ====
`ifndef URDR_MAP_SVH
`define URDR_MAP_SVH

// Register byte offsets
`define URDR_OFS_CTRL 8'h00
`define URDR_OFS_BAUD 8'h04
`define URDR_OFS_STATUS 8'h08
`define URDR_OFS_DATA 8'h0C

// Control register fields and reset values
`define URDR_CTRL_ENABLE_BIT 0
`define URDR_CTRL_NINE_BIT 1
`define URDR_CTRL_RESET 2'h0
`define URDR_BAUD_RESET 13'h0001

// Status register fields
`define URDR_STAT_FULL_BIT 0
`define URDR_STAT_NOISE_BIT 1
`define URDR_STAT_FRAMING_BIT 2
`define URDR_STAT_ACTIVE_BIT 3

// Sample slots within one bit time, counted from zero (slot 1 is 4'h0)
`define URDR_SLOTS_PER_BIT 16
`define URDR_SLOT_FIRST 4'h0
`define URDR_SLOT_VERIFY_A 4'h2
`define URDR_SLOT_VERIFY_B 4'h4
`define URDR_SLOT_VERIFY_C 4'h6
`define URDR_SLOT_DATA_A 4'h7
`define URDR_SLOT_DATA_B 4'h8
`define URDR_SLOT_DATA_C 4'h9
`define URDR_SLOT_LAST 4'hF

// Data bits per frame
`define URDR_BITS_SHORT 4'h8
`define URDR_BITS_LONG 4'h9

`endif

// ==== urdr_pkg.sv ====
package urdr_pkg;

    typedef enum logic [1:0] {
        URDR_HUNT = 2'b00,
        URDR_START = 2'b01,
        URDR_DATA = 2'b11,
        URDR_STOP = 2'b10
    } urdr_state_t;

    typedef struct packed {
        logic nineBit;
        logic rxEnable;
    } urdr_ctrl_t;

    typedef struct packed {
        logic framingErrorFlag;
        logic noiseFlag;
        logic rxBufferFullFlag;
    } urdr_flags_t;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
    } urdr_phase_t;

    function automatic logic urdr_majority(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : urdr_majority

    function automatic logic urdr_disagree(input logic [2:0] v);
        return (v != 3'h0) && (v != 3'h7);
    endfunction : urdr_disagree

endpackage : urdr_pkg

// ==== urdr_tick_gen.sv ====
`timescale 1ns/1ps

// Divides the module clock down to the sixteen-per-bit sampling rate
module urdr_tick_gen #(
    parameter int DIV_W = 13
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);

    logic [DIV_W-1:0] count;
    logic running;

    generate
        if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
            $error("urdr_tick_gen: DIV_W must be 1 to 16");
        end
    endgenerate

    // A zero divisor stops the sampling clock
    assign running = enable && (divisor != '0);
    assign tick = running && (count == divisor - 1'b1);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (!running || tick) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule : urdr_tick_gen

// ==== urdr_edge_search.sv ====
`timescale 1ns/1ps

// Keeps the last three samples and flags falling edges
module urdr_edge_search (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic rxd,
    input wire logic restart,
    output logic startEdge,
    output logic anyFall
);

    logic [2:0] history;

    assign startEdge = tick && (history == 3'h7) && !rxd;
    assign anyFall = tick && history[0] && !rxd;

    // Restart forgets old highs so a fresh run of three is needed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            history <= 3'h0;
        end else if (restart) begin
            history <= 3'h0;
        end else if (tick) begin
            history <= {history[1:0], rxd};
        end
    end

endmodule : urdr_edge_search

// ==== urdr_rx_top.sv ====
// Notes on behaviour
// R1 - The line is sampled at sixteen ticks per bit time.
// R2 - The tick count restarts on each start bit and on a one-to-zero data transition.
// R3 - A start bit is a low sample after three high samples, and counting begins there.
// R4 - Start samples at slots 3, 5 and 7 accept on at most one high, noise on exactly one.
// R5 - A failed start check resets the tick count and searches again.
// R6 - A failed start check leaves the noise flag alone.
// R7 - Each data bit is the majority of slots 8 to 10, noise when they differ.
// R8 - In the start bit, high samples at slots 8 to 10 only raise noise.
// R9 - The stop bit is voted at slots 8 to 10, low majority is a framing error.
// R10 - A missing stop level, a break included, raises the framing error.
// R11 - The framing error appears in the same cycle as the buffer full flag.
// R12 - A finished frame moves its data to the buffer and sets buffer full.
// R13 - A length setting picks 8 or 9 data bits, the ninth kept as data bit 8.
// R14 - Noise gathers over the whole frame and is shown with buffer full.
`timescale 1ns/1ps

`include "urdr_map.svh"

module urdr_rx_top
    import urdr_pkg::*;
#(
    parameter int DIV_W = 13
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxd
);

    generate
        if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
            $error("urdr_rx_top: DIV_W must be 1 to 16");
        end
    endgenerate

    // Register state
    urdr_ctrl_t ctrl;
    logic [DIV_W-1:0] baudDivisor;
    urdr_flags_t flags;
    logic [8:0] rxBuffer;
    logic rxNinthBit;

    // Bus phase tracking
    urdr_phase_t dataPhase;
    logic wrPending;
    logic accept;
    logic readData;
    logic [31:0] next_hrdata;

    // Recovery state
    urdr_state_t state;
    urdr_state_t next_state;
    logic [3:0] sampleTick;
    logic [3:0] next_sampleTick;
    logic [3:0] bitCount;
    logic [3:0] next_bitCount;
    logic [3:0] frameBits;
    logic [2:0] votes;
    logic [2:0] next_votes;
    logic [2:0] vote;
    logic [8:0] shiftReg;
    logic [8:0] next_shiftReg;
    logic noiseAcc;
    logic next_noiseAcc;
    logic lastBitOne;
    logic next_lastBitOne;
    logic bitVoted;
    logic next_bitVoted;
    logic [4:0] edgeAge;
    logic bitValue;

    // Frame completion
    logic frameDone;
    logic frameFramingError;
    logic frameNoise;
    logic [8:0] frameData;
    logic huntRestart;

    // Sampling and edge helpers
    logic tick;
    logic startEdge;
    logic anyFall;

    assign rxNinthBit = rxBuffer[8];
    assign frameBits = ctrl.nineBit ? `URDR_BITS_LONG : `URDR_BITS_SHORT; // R13

    urdr_tick_gen #(
        .DIV_W(DIV_W)
    ) u_tick (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(ctrl.rxEnable),
        .divisor(baudDivisor),
        .tick(tick)
    );

    urdr_edge_search u_edge (
        .mclk(mclk),
        .reset_n(reset_n),
        .tick(tick),
        .rxd(rxd),
        .restart(huntRestart),
        .startEdge(startEdge),
        .anyFall(anyFall)
    );

    // Recovery datapath and sequencing

    always_comb begin
        next_state = state;
        next_sampleTick = sampleTick;
        next_bitCount = bitCount;
        next_votes = votes;
        next_shiftReg = shiftReg;
        next_noiseAcc = noiseAcc;
        next_lastBitOne = lastBitOne;
        next_bitVoted = bitVoted;
        vote = {votes[1:0], rxd};
        bitValue = urdr_majority(vote);
        frameDone = 1'b0;
        frameFramingError = 1'b0;
        frameNoise = noiseAcc;
        huntRestart = 1'b0;
        if (!ctrl.rxEnable) begin
            next_state = URDR_HUNT;
            next_sampleTick = `URDR_SLOT_FIRST;
            huntRestart = 1'b1;
        end else if (tick) begin
            unique case (state)
                URDR_HUNT: begin
                    if (startEdge) begin
                        next_state = URDR_START; // R3
                        // The edge sample itself is slot 1
                        next_sampleTick = `URDR_SLOT_FIRST + 4'h1; // R2
                        next_noiseAcc = 1'b0;
                        next_votes = 3'h0;
                    end
                end
                URDR_START: begin
                    next_sampleTick = sampleTick + 4'h1; // R1
                    if (sampleTick == `URDR_SLOT_VERIFY_A || sampleTick == `URDR_SLOT_VERIFY_B) begin
                        next_votes = vote;
                    end
                    if (sampleTick == `URDR_SLOT_VERIFY_C) begin
                        next_votes = 3'h0;
                        if (bitValue) begin
                            // Noise before a real start bit is not reported
                            next_state = URDR_HUNT; // R5
                            next_sampleTick = `URDR_SLOT_FIRST; // R5
                            huntRestart = 1'b1; // R5
                            next_noiseAcc = 1'b0; // R6
                        end else if (urdr_disagree(vote)) begin
                            next_noiseAcc = 1'b1; // R4
                        end
                    end
                    if ((sampleTick == `URDR_SLOT_DATA_A || sampleTick == `URDR_SLOT_DATA_B
                            || sampleTick == `URDR_SLOT_DATA_C) && rxd) begin
                        next_noiseAcc = 1'b1; // R8
                    end
                    if (sampleTick == `URDR_SLOT_LAST) begin
                        next_state = URDR_DATA;
                        next_bitCount = 4'h0;
                        next_lastBitOne = 1'b0; // R2
                        next_bitVoted = 1'b0;
                    end
                end
                URDR_DATA: begin
                    next_sampleTick = sampleTick + 4'h1;
                    if (sampleTick == `URDR_SLOT_DATA_A || sampleTick == `URDR_SLOT_DATA_B) begin
                        next_votes = vote;
                    end
                    // A resync may move the count back, so each bit is voted once
                    if (sampleTick == `URDR_SLOT_DATA_C && !bitVoted) begin
                        next_votes = 3'h0;
                        next_bitVoted = 1'b1;
                        next_shiftReg = {bitValue, shiftReg[8:1]}; // R7
                        if (urdr_disagree(vote)) begin
                            next_noiseAcc = 1'b1; // R7 R14
                        end
                        next_lastBitOne = bitValue;
                        next_bitCount = bitCount + 4'h1;
                        // Realign so the falling edge that began this zero bit is slot 1
                        if (lastBitOne && !bitValue && edgeAge < 5'h0E) begin
                            next_sampleTick = edgeAge[3:0] + 4'h2; // R2
                        end
                    end
                    if (sampleTick == `URDR_SLOT_LAST) begin
                        next_bitVoted = 1'b0;
                    end
                    if (sampleTick == `URDR_SLOT_LAST && bitCount == frameBits) begin
                        next_state = URDR_STOP; // R13
                    end
                end
                URDR_STOP: begin
                    next_sampleTick = sampleTick + 4'h1;
                    if (sampleTick == `URDR_SLOT_DATA_A || sampleTick == `URDR_SLOT_DATA_B) begin
                        next_votes = vote;
                    end
                    if (sampleTick == `URDR_SLOT_DATA_C) begin
                        next_votes = 3'h0;
                        frameDone = 1'b1; // R12
                        frameFramingError = !bitValue; // R9 R10
                        frameNoise = noiseAcc | urdr_disagree(vote); // R9 R14
                        next_state = URDR_HUNT;
                        next_sampleTick = `URDR_SLOT_FIRST;
                        huntRestart = 1'b1;
                    end
                end
            endcase
        end
    end

    // Right-justify the payload of a short frame
    assign frameData = ctrl.nineBit ? shiftReg : {1'b0, shiftReg[8:1]}; // R13

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= URDR_HUNT;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sampleTick <= `URDR_SLOT_FIRST;
            bitCount <= 4'h0;
            votes <= 3'h0;
        end else begin
            sampleTick <= next_sampleTick; // R1
            bitCount <= next_bitCount;
            votes <= next_votes;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg <= 9'h000;
            noiseAcc <= 1'b0;
            lastBitOne <= 1'b0;
            bitVoted <= 1'b0;
        end else begin
            shiftReg <= next_shiftReg;
            noiseAcc <= next_noiseAcc;
            lastBitOne <= next_lastBitOne;
            bitVoted <= next_bitVoted;
        end
    end

    // Ticks since the last falling edge, saturating
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            edgeAge <= 5'h1F;
        end else if (anyFall) begin
            edgeAge <= 5'h00;
        end else if (tick && edgeAge != 5'h1F) begin
            edgeAge <= edgeAge + 5'h01;
        end
    end

    // Bus slave

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign accept = hsel && htrans[1] && hready;
    assign readData = accept && !hwrite && (haddr[31:8] == 24'h00_0000)
        && (haddr[7:0] == `URDR_OFS_DATA);

    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (accept && !hwrite && haddr[31:8] == 24'h00_0000) begin
            unique case (haddr[7:0])
                `URDR_OFS_CTRL: next_hrdata = {30'h0, ctrl};
                `URDR_OFS_BAUD: next_hrdata = 32'(baudDivisor);
                `URDR_OFS_STATUS: begin
                    next_hrdata[`URDR_STAT_FULL_BIT] = flags.rxBufferFullFlag;
                    next_hrdata[`URDR_STAT_NOISE_BIT] = flags.noiseFlag;
                    next_hrdata[`URDR_STAT_FRAMING_BIT] = flags.framingErrorFlag;
                    next_hrdata[`URDR_STAT_ACTIVE_BIT] = (state != URDR_HUNT);
                end
                `URDR_OFS_DATA: next_hrdata = {23'h0, rxNinthBit, rxBuffer[7:0]};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (accept) begin
            hrdata <= next_hrdata;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrPending <= 1'b0;
            dataPhase <= '0;
        end else if (hready) begin
            wrPending <= accept && hwrite && (haddr[31:8] == 24'h00_0000);
            dataPhase <= '{addr: haddr[7:0], write: hwrite};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= urdr_ctrl_t'(`URDR_CTRL_RESET);
            baudDivisor <= DIV_W'(`URDR_BAUD_RESET);
        end else if (wrPending && dataPhase.write) begin
            if (dataPhase.addr == `URDR_OFS_CTRL) begin
                ctrl <= urdr_ctrl_t'(hwdata[1:0]);
            end
            if (dataPhase.addr == `URDR_OFS_BAUD) begin
                baudDivisor <= hwdata[DIV_W-1:0];
            end
        end
    end

    // Receive buffer and flags

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxBuffer <= 9'h000;
        end else if (frameDone) begin
            rxBuffer <= frameData; // R12
        end
    end

    // A finishing frame wins over a data read in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
        end else if (frameDone) begin
            flags.rxBufferFullFlag <= 1'b1; // R11 R12
            flags.framingErrorFlag <= frameFramingError; // R11
            flags.noiseFlag <= frameNoise; // R14
        end else if (readData) begin
            flags <= '0;
        end
    end

endmodule : urdr_rx_top

// ==== urdr_rx_chk.sv ====
`timescale 1ns/1ps

`include "urdr_map.svh"

module urdr_rx_chk #(
    parameter int DIV_W = 13
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    logic ctrlWrite;
    logic [1:0] ctrlShadow;

    // Mirrors the control register from completed writes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlWrite <= 1'b0;
            ctrlShadow <= 2'h0;
        end else begin
            if (ctrlWrite) begin
                ctrlShadow <= hwdata[1:0];
            end
            ctrlWrite <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_take;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_read(a);
        s_take ##0 (!hwrite && haddr == a);
    endsequence

    property p_ready;
        hreadyout == 1'b1;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_unmapped;
        s_take ##0 (!hwrite && haddr[31:4] != 28'h0) |=> hrdata == 32'h0;
    endproperty
    property p_ctrl_back;
        s_read(`URDR_OFS_CTRL) |=> hrdata == {30'h0, ctrlShadow};
    endproperty
    property p_status_width;
        s_read(`URDR_OFS_STATUS) |=> hrdata[31:4] == 28'h0;
    endproperty
    property p_framing_full;
        s_read(`URDR_OFS_STATUS) |=> !hrdata[2] || hrdata[0];
    endproperty
    property p_noise_full;
        s_read(`URDR_OFS_STATUS) |=> !hrdata[1] || hrdata[0];
    endproperty
    property p_data_width;
        s_read(`URDR_OFS_DATA) |=> hrdata[31:9] == 23'h0;
    endproperty

    a_ready: assert property (p_ready) else $error("ready low");
    a_okay: assert property (p_okay) else $error("error response");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
    a_status_width: assert property (p_status_width) else $error("status high bits set");
    a_framing_full: assert property (p_framing_full)
        else $error("framing error without full");
    a_noise_full: assert property (p_noise_full)
        else $error("noise without full");
    a_data_width: assert property (p_data_width)
        else $error("data high bits set");
endmodule : urdr_rx_chk

bind urdr_rx_top urdr_rx_chk #(.DIV_W(DIV_W)) urdr_rx_chk_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
);

// ==== urdr_tx_model.sv ====
`timescale 1ns/1ps

// Far-end transmitter: idle high, start, data LSB first, stop
module urdr_tx_model (
    input wire logic mclk,
    output logic txd
);
    initial txd = 1'b1;

    // Sixteen slots plus extra, each of slotLen cycles; a mask bit flips one of the first sixteen slots
    task automatic send_bit(input logic lvl, input logic [15:0] mask, input int slotLen,
        input int extra);
        for (int j = 0; j < 16 + extra; j++) begin
            @(posedge mclk);
            txd <= (j < 16) ? lvl ^ mask[j] : lvl;
            repeat (slotLen - 1) @(posedge mclk);
        end
    endtask : send_bit

    task automatic send_frame(input logic [8:0] d, input int nBits, input int slotLen,
        input int extra, input logic [15:0] sm, fm, input logic sl, input logic [15:0] pm);
        send_bit(1'b0, sm, slotLen, extra);
        for (int i = 0; i < nBits; i++) begin
            send_bit(d[i], (i == 0) ? fm : 16'h0, slotLen, extra);
        end
        send_bit(sl, pm, slotLen, extra);
        // Trailing idle gives the three highs the next start needs
        send_bit(1'b1, 16'h0, slotLen, 0);
    endtask : send_frame
endmodule : urdr_tx_model

// ==== urdr_rx_top_bench.sv ====
`timescale 1ns/1ps

`include "urdr_map.svh"

module urdr_rx_top_bench;
    localparam logic [31:0] CTRL = {24'h0, `URDR_OFS_CTRL};
    localparam logic [31:0] BAUD = {24'h0, `URDR_OFS_BAUD};
    localparam logic [31:0] STAT = {24'h0, `URDR_OFS_STATUS};
    localparam logic [31:0] DATA = {24'h0, `URDR_OFS_DATA};
    logic mclk;
    logic reset_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic rxd;
    int errors = 0;
    int numChecks = 0;
    int cycles = 0;
    logic [15:0] rejMask [4] = '{16'h0050, 16'h0044, 16'h0014, 16'h0054};

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    assign hready = hreadyout;

    urdr_rx_top #(.DIV_W(13)) urdr_rx_top_inst (
        .mclk(mclk),
        .reset_n(reset_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .rxd(rxd)
    );
    urdr_tx_model urdr_tx_model_inst (.mclk(mclk), .txd(rxd));

    task automatic complete_run;
        $display("checks %0d, errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string n, input logic [31:0] seen, exp);
        numChecks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input string n, input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(n, r, e);
    endtask : rdc

    // Status, data, then flags gone after the data read
    task automatic result(input logic [8:0] ed, input logic [3:0] es);
        rdc("status", STAT, {28'h0, es});
        rdc("data", DATA, {23'h0, ed});
        rdc("cleared", STAT, 32'h0);
    endtask : result

    task automatic run_case(input logic [15:0] sm, fm, pm, input logic sl,
        input logic [8:0] d, ed, input logic [3:0] es);
        urdr_tx_model_inst.send_frame(d, 8, 1, 0, sm, fm, sl, pm);
        result(ed, es);
    endtask : run_case

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        rdc("ctrl", CTRL, 32'h0);
        rdc("baud", BAUD, 32'h1);
        rdc("status", STAT, 32'h0);
        rdc("data", DATA, 32'h0);
        rdc("unmapped", 32'h100, 32'h0);
        rdc("gap", 32'h10, 32'h0);
        wr(32'h100, 32'h3);
        rdc("ctrl", CTRL, 32'h0);
        // Receiver disabled: a frame leaves no trace
        urdr_tx_model_inst.send_frame(9'h0A5, 8, 1, 0, 16'h0, 16'h0, 1'b1, 16'h0);
        rdc("idle", STAT, 32'h0);
        wr(CTRL, 32'h1);
        rdc("ctrl", CTRL, 32'h1);
        run_case(16'h0000, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h1);
        run_case(16'h0040, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0010, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0004, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0380, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0100, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0000, 16'h0100, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0000, 16'h0180, 16'h0, 1'b1, 9'h0A5, 9'h0A4, 4'h3);
        run_case(16'h0000, 16'h0, 16'h0080, 1'b1, 9'h0A5, 9'h0A5, 4'h3);
        run_case(16'h0000, 16'h0, 16'h0300, 1'b1, 9'h0A5, 9'h0A5, 4'h7);
        run_case(16'h0000, 16'h0, 16'h0000, 1'b0, 9'h0A5, 9'h0A5, 4'h5);
        run_case(16'h0000, 16'h0, 16'h0200, 1'b0, 9'h0A5, 9'h0A5, 4'h7);
        run_case(16'h0000, 16'h0, 16'h0000, 1'b0, 9'h000, 9'h000, 4'h5);
        // Rejected starts, then a clean frame must come out noise free
        foreach (rejMask[i]) begin
            urdr_tx_model_inst.send_bit(1'b0, rejMask[i], 1, 0);
            urdr_tx_model_inst.send_bit(1'b1, 16'h0, 1, 0);
            rdc("rejected", STAT, 32'h0);
            run_case(16'h0, 16'h0, 16'h0, 1'b1, 9'h0A5, 9'h0A5, 4'h1);
        end
        // Slow sender: one extra cycle per bit needs resync
        urdr_tx_model_inst.send_frame(9'h055, 8, 1, 1, 16'h0, 16'h0, 1'b1, 16'h0);
        result(9'h055, 4'h1);
        wr(BAUD, 32'h3);
        rdc("baud", BAUD, 32'h3);
        urdr_tx_model_inst.send_frame(9'h05A, 8, 3, 0, 16'h0, 16'h0, 1'b1, 16'h0);
        result(9'h05A, 4'h1);
        wr(BAUD, 32'h1);
        wr(CTRL, 32'h3);
        fork
            urdr_tx_model_inst.send_frame(9'h1C3, 9, 1, 0, 16'h0, 16'h0, 1'b1, 16'h0);
            begin
                repeat (60) @(posedge mclk);
                rdc("active", STAT, 32'h8);
            end
        join
        result(9'h1C3, 4'h1);
        complete_run();
    end
endmodule : urdr_rx_top_bench
